// [include/nasl_pkg.sv]
// Package for the node address and status indicator block.
// Assumes a single 10 MHz system clock and no register bus.
package nasl_pkg;

  // ==========================================================================
  // Address
  localparam logic [6:0] ADDR_FACTORY    = 7'h01;
  localparam logic [3:0] DIGIT_MAX       = 4'h9;
  localparam logic [3:0] TENS_WEIGHT     = 4'hA;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ         = 10000000;
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int unsigned FLASH_CNT_W    = 22;

  // ==========================================================================
  // Communication phases and cyclic field layout
  typedef enum logic [2:0] {
    NASL_CP0 = 3'h0,
    NASL_CP1 = 3'h1,
    NASL_CP2 = 3'h2,
    NASL_CP3 = 3'h3,
    NASL_CP4 = 3'h4
  } nasl_phase_t;

  localparam logic [15:0] WORD_CLEAR     = 16'h0000;
  localparam int unsigned CONN_IDX_AT    = 0;
  localparam int unsigned CONN_IDX_MDT   = 1;

  // Cyclic control and status words carried together
  typedef struct packed {
    logic [15:0] conn_ctrl;
    logic [15:0] pos_ctrl;
    logic [15:0] drive_status_container;
  } nasl_cyc_t;

  // Stored address parameter write from the bus side
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } nasl_addr_wr_t;

endpackage

// [rtl/nasl_flash.sv]
// Free-running blink generator for the motor supply indicator.
// Assumes clk_sys at the package clock rate.
`timescale 1ns/1ps
module nasl_flash (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Blink phase
  output logic      blink
);

  logic [nasl_pkg::FLASH_CNT_W-1:0] cnt_reg;
  logic                             blink_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg   <= '0;
      blink_reg <= 1'b0;
    end else if (cnt_reg == nasl_pkg::FLASH_CNT_W'(nasl_pkg::FLASH_HALF_CYC - 1)) begin
      cnt_reg   <= '0;
      blink_reg <= ~blink_reg;
    end else begin
      cnt_reg   <= cnt_reg + 1'b1;
    end
  end

  assign blink = blink_reg;

endmodule

// [rtl/nasl_top.sv]
// Node address selection, status indicators and cyclic word clearing.
// Assumes synchronous inputs; the non-volatile store is outside and answers
// with its saved value at power-up through nv_addr/nv_valid.
// What this block does
// - With no address ever configured the device presents node address 1.
// - A bus write of the address parameter is adopted as the new stored address.
// - Switches at 00 or not fitted mean the stored parameter gives the address.
// - Switches above 00 give the address and bus address writes are ignored.
// - Every accepted parameter write is handed to non-volatile storage one cycle later through the nv_save register.
// - The two switches are combined as tens and ones decimal digits.
// - Motor indicator is steady when supply is ok and flashes if still in factory state.
// - Motor indicator is off whenever the supply is out of range.
// - Each of the two ports has its own green link indicator following its link.
// - Cyclic data uses the fixed-configuration I/O profile only.
// - Connection index 0 sets up the producer telegram and index 1 the consumer telegram.
// - On CP3 to CP4 the connection control, positioning control and status container clear to zero.
`timescale 1ns/1ps
module nasl_top (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Address switches
  input  wire logic                   sw_fitted,
  input  wire logic [3:0]             sw_tens,
  input  wire logic [3:0]             sw_ones,
  // Address parameter from the bus
  input  wire nasl_pkg::nasl_addr_wr_t addr_wr,
  // Non-volatile store
  input  wire logic                   nv_valid,
  input  wire logic                   nv_configured,
  input  wire logic [6:0]             nv_addr,
  output nasl_pkg::nasl_addr_wr_t     nv_save,
  // Supply and links
  input  wire logic                   motor_supply_ok,
  input  wire logic [1:0]             port_link_up,
  // Communication phase and cyclic words
  input  wire nasl_pkg::nasl_phase_t  comm_phase,
  input  wire logic                   conn_sel,
  input  wire logic                   cyc_wr,
  input  wire nasl_pkg::nasl_cyc_t    cyc_in,
  output nasl_pkg::nasl_cyc_t         cyc_out,
  output logic [1:0]                  conn_target,
  // Results
  output logic [6:0]                  node_addr,
  output logic                        addr_from_switch,
  output logic                        configured,
  output logic                        motor_led,
  output logic [1:0]                  port_link_indicators
);

  // ==========================================================================
  // Helpers
  function automatic logic [6:0] dec2(input logic [3:0] t, input logic [3:0] o);
    logic [7:0] v;
    v = 8'(t) * 8'(nasl_pkg::TENS_WEIGHT) + 8'(o);
    return v[6:0];
  endfunction

  function automatic logic digit_ok(input logic [3:0] d);
    return d <= nasl_pkg::DIGIT_MAX;
  endfunction

  // ==========================================================================
  // Switch decode
  logic [6:0] sw_value;
  logic       sw_decimal;
  logic       sw_active;

  always_comb begin
    sw_value  = dec2(sw_tens, sw_ones);
    // Non-decimal positions are treated as 00 so a bad switch never gives a wild address
    sw_decimal = digit_ok(sw_tens) && digit_ok(sw_ones);
    sw_active  = sw_fitted && sw_decimal && (sw_value != 7'h00);
  end

  // ==========================================================================
  // Stored address parameter
  logic [6:0]              stored_addr_reg;
  logic                    configured_reg;
  nasl_pkg::nasl_addr_wr_t nv_save_reg;
  logic                    accept_wr;

  // A write refused under the switches leaves no trace, not even in the store
  assign accept_wr = addr_wr.valid && !sw_active;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stored_addr_reg <= nasl_pkg::ADDR_FACTORY;
      configured_reg  <= 1'b0;
    end else if (accept_wr) begin
      stored_addr_reg <= addr_wr.addr;
      configured_reg  <= 1'b1;
    end else if (nv_valid && nv_configured) begin
      // Restore after restart; a live write in the same cycle wins
      stored_addr_reg <= nv_addr;
      configured_reg  <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nv_save_reg <= '0;
    end else begin
      nv_save_reg.valid <= accept_wr;
      nv_save_reg.addr  <= addr_wr.addr;
    end
  end

  // ==========================================================================
  // Effective address
  // The stored parameter is never overwritten by the switch value, so turning
  // the switches back to 00 brings the bus-assigned address back
  logic [6:0] node_addr_reg;
  logic       from_sw_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      node_addr_reg <= nasl_pkg::ADDR_FACTORY;
      from_sw_reg   <= 1'b0;
    end else begin
      node_addr_reg <= sw_active ? sw_value : stored_addr_reg;
      from_sw_reg   <= sw_active;
    end
  end

  // ==========================================================================
  // Indicators
  logic       blink;
  logic       motor_led_reg;
  logic [1:0] link_reg;
  logic       factory_state;

  nasl_flash u_flash (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .blink   (blink)
  );

  // Factory state: nothing stored and no switch setting.
  // Blink starts dark after reset, so a fresh device shows the indicator off
  // for the first half period before its first flash.
  assign factory_state = !configured_reg && !sw_active;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      motor_led_reg <= 1'b0;
    end else if (!motor_supply_ok) begin
      motor_led_reg <= 1'b0;
    end else begin
      motor_led_reg <= factory_state ? blink : 1'b1;
    end
  end

  // Bit i follows port i+1 with no stretching; a bouncing link shows as it is
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_link
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          link_reg[gi] <= 1'b0;
        end else begin
          link_reg[gi] <= port_link_up[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Phase tracking and cyclic words
  nasl_pkg::nasl_phase_t phase_reg;
  nasl_pkg::nasl_cyc_t   cyc_reg;
  logic [1:0]            conn_target_reg;
  logic                  cp3_to_cp4;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= nasl_pkg::NASL_CP0;
    end else begin
      phase_reg <= comm_phase;
    end
  end

  // Only a direct CP3 to CP4 step clears; falling back to a lower phase keeps the words
  assign cp3_to_cp4 = (phase_reg == nasl_pkg::NASL_CP3) && (comm_phase == nasl_pkg::NASL_CP4);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cyc_reg <= '0;
    end else if (cp3_to_cp4) begin
      // Clearing wins over a same-cycle write so CP4 starts from known words
      cyc_reg.conn_ctrl              <= nasl_pkg::WORD_CLEAR;
      cyc_reg.pos_ctrl               <= nasl_pkg::WORD_CLEAR;
      cyc_reg.drive_status_container <= nasl_pkg::WORD_CLEAR;
    end else if (cyc_wr) begin
      cyc_reg <= cyc_in;
    end
  end

  // One-hot target of a connection setting: bit0 producer (AT), bit1 consumer (MDT)
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conn_target_reg <= 2'h0;
    end else begin
      case (conn_sel)
        1'(nasl_pkg::CONN_IDX_AT):  conn_target_reg <= 2'h1;
        1'(nasl_pkg::CONN_IDX_MDT): conn_target_reg <= 2'h2;
        default:                    conn_target_reg <= 2'h0;
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  // Every output is a register copy so no decode glitch reaches a pin
  assign node_addr            = node_addr_reg;
  assign addr_from_switch     = from_sw_reg;
  assign configured           = configured_reg;
  assign motor_led            = motor_led_reg;
  assign port_link_indicators = link_reg;
  assign nv_save              = nv_save_reg;
  assign cyc_out              = cyc_reg;
  assign conn_target          = conn_target_reg;

endmodule

// [testbench/nasl_checker.sv]
// Assertions on the ports of nasl_top.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module nasl_checker (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  // Inputs
  input wire logic                    sw_fitted,
  input wire logic [3:0]              sw_tens,
  input wire logic [3:0]              sw_ones,
  input wire nasl_pkg::nasl_addr_wr_t addr_wr,
  input wire logic                    motor_supply_ok,
  input wire logic [1:0]              port_link_up,
  input wire nasl_pkg::nasl_phase_t   comm_phase,
  input wire logic                    conn_sel,
  // Outputs
  input wire nasl_pkg::nasl_addr_wr_t nv_save,
  input wire nasl_pkg::nasl_cyc_t     cyc_out,
  input wire logic [1:0]              conn_target,
  input wire logic [6:0]              node_addr,
  input wire logic                    addr_from_switch,
  input wire logic                    configured,
  input wire logic                    motor_led,
  input wire logic [1:0]              port_link_indicators
);
  logic       sw_act;
  logic [6:0] sw_val;
  // Non-decimal digits count as switch 00
  assign sw_act = sw_fitted && sw_tens <= 4'h9 && sw_ones <= 4'h9 && {sw_tens, sw_ones} != 8'h00;
  assign sw_val = 7'(sw_tens) * 7'h0A + 7'(sw_ones);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Properties
  property p_link; 1'b1 |=> port_link_indicators == $past(port_link_up); endproperty
  a_link: assert property (p_link) else $error("link indicator lag wrong");
  property p_off; !motor_supply_ok |=> !motor_led; endproperty
  a_off: assert property (p_off) else $error("motor indicator lit without supply");
  property p_on; motor_supply_ok && configured |=> motor_led; endproperty
  a_on: assert property (p_on) else $error("motor indicator not steady");
  property p_sw; sw_act |=> node_addr == $past(sw_val) && addr_from_switch; endproperty
  a_sw: assert property (p_sw) else $error("switch address wrong");
  property p_refuse; sw_act && addr_wr.valid |=> !nv_save.valid; endproperty
  a_refuse: assert property (p_refuse) else $error("write taken under switches");
  property p_save; !sw_act && addr_wr.valid |=> nv_save.valid && nv_save.addr == $past(addr_wr.addr); endproperty
  a_save: assert property (p_save) else $error("address write not stored");
  property p_clr; comm_phase == nasl_pkg::NASL_CP4 && $past(comm_phase) == nasl_pkg::NASL_CP3 |=> cyc_out == '0; endproperty
  a_clr: assert property (p_clr) else $error("cyclic words not cleared");
  property p_conn; 1'b1 |=> conn_target == ($past(conn_sel) ? 2'b10 : 2'b01); endproperty
  a_conn: assert property (p_conn) else $error("connection target wrong");
  property p_stored; !sw_act |=> !addr_from_switch; endproperty
  a_stored: assert property (p_stored) else $error("switch flag set without switch address");
  property p_factory; !sw_act && !configured |=> node_addr == 7'h01; endproperty
  a_factory: assert property (p_factory) else $error("factory address not presented");
endmodule

bind nasl_top nasl_checker u_chk (.clk_sys, .reset_n, .sw_fitted, .sw_tens, .sw_ones, .addr_wr, .motor_supply_ok,
  .port_link_up, .comm_phase, .conn_sel, .nv_save, .cyc_out, .conn_target, .node_addr, .addr_from_switch,
  .configured, .motor_led, .port_link_indicators);

// [testbench/nasl_nv_model.sv]
// Non-volatile address store on the far side of nasl_top.
// Assumes it keeps its content across reset_n, as a real store would.
`timescale 1ns/1ps
module nasl_nv_model (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  // Store port
  input wire nasl_pkg::nasl_addr_wr_t nv_save,
  output logic                        nv_valid,
  output logic                        nv_configured,
  output logic [6:0]                  nv_addr
);
  logic [6:0] mem_reg = 7'h00;
  logic       used_reg = 1'b0;
  logic       boot_reg;
  always @(posedge clk_sys) begin
    if (nv_save.valid) begin
      mem_reg <= nv_save.addr;
      used_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) boot_reg <= 1'b1;
    else boot_reg <= 1'b0;
  end
  // Saved value shown for one cycle after release; nv_addr shows its inverse otherwise
  assign nv_valid = boot_reg && reset_n;
  assign nv_configured = nv_valid && used_reg;
  assign nv_addr = nv_valid ? mem_reg : ~mem_reg;
endmodule

// [testbench/tb_node_address_and_status_leds.sv]
// Self-checking bench for nasl_top with the store model.
// Assumes outputs read at an edge show the previous edge's results.
`timescale 1ns/1ps
module tb_node_address_and_status_leds;
  logic                    clk_sys, reset_n, sw_fitted, nv_valid, nv_configured, motor_supply_ok, conn_sel, cyc_wr;
  logic                    addr_from_switch, configured, motor_led;
  logic [3:0]              sw_tens, sw_ones;
  logic [6:0]              nv_addr, node_addr;
  logic [1:0]              port_link_up, conn_target, port_link_indicators;
  logic [15:0]             sw_tab [4] = '{16'h472F, 16'h9963, 16'h0101, 16'h100A};
  nasl_pkg::nasl_addr_wr_t addr_wr, nv_save;
  nasl_pkg::nasl_phase_t   comm_phase;
  nasl_pkg::nasl_cyc_t     cyc_in, cyc_out;
  int                      failures, checked, cycles;
  nasl_top DUT (.clk_sys, .reset_n, .sw_fitted, .sw_tens, .sw_ones, .addr_wr, .nv_valid, .nv_configured, .nv_addr,
    .nv_save, .motor_supply_ok, .port_link_up, .comm_phase, .conn_sel, .cyc_wr, .cyc_in, .cyc_out, .conn_target,
    .node_addr, .addr_from_switch, .configured, .motor_led, .port_link_indicators);
  nasl_nv_model u_nv (.clk_sys, .reset_n, .nv_save, .nv_valid, .nv_configured, .nv_addr);
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One-cycle write pulse, entered and left on an edge
  task automatic wr_addr(input logic [6:0] a);
    addr_wr <= '{valid: 1'b1, addr: a};
    tick(1);
    addr_wr <= '{valid: 1'b0, addr: a};
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    {reset_n, sw_fitted, sw_tens, sw_ones, motor_supply_ok, port_link_up, conn_sel, cyc_wr} = '0;
    addr_wr = '0;
    comm_phase = nasl_pkg::NASL_CP0;
    cyc_in = '0;
    tick(6);
    reset_n <= 1'b1;
    tick(3);
    check("factory addr", 48'h01, 48'(node_addr));
    check("motor no supply", 48'h0, 48'(motor_led));
    for (int i = 0; i < 4; i++) begin
      port_link_up <= 2'(i);
      tick(2);
      check("link", 48'(i), 48'(port_link_indicators));
    end
    $display("test factory and links done");
    motor_supply_ok <= 1'b1;
    tick(2);
    check("motor factory flash", 48'h0, 48'(motor_led));
    wr_addr(7'h2A);
    tick(4);
    check("bus addr", 48'h2A, 48'(node_addr));
    check("motor steady", 48'h1, 48'(motor_led));
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(4);
    check("restored addr", 48'h2A, 48'(node_addr));
    $display("test bus address done");
    sw_fitted <= 1'b1;
    foreach (sw_tab[k]) begin
      {sw_tens, sw_ones} <= sw_tab[k][15:8];
      tick(2);
      check("switch addr", 48'(sw_tab[k][7:0]), 48'(node_addr));
    end
    wr_addr(7'h05);
    tick(4);
    check("refused write", 48'h0A, 48'(node_addr));
    {sw_tens, sw_ones} <= 8'h00;
    tick(2);
    check("switch 00", 48'h2A, 48'(node_addr));
    $display("test switches done");
    check("conn target at", 48'h1, 48'(conn_target));
    conn_sel <= 1'b1;
    tick(2);
    check("conn target", 48'h2, 48'(conn_target));
    comm_phase <= nasl_pkg::NASL_CP3;
    cyc_in <= 48'h123456789ABC;
    cyc_wr <= 1'b1;
    tick(1);
    comm_phase <= nasl_pkg::NASL_CP4;
    tick(1);
    cyc_wr <= 1'b0;
    tick(2);
    check("cyclic clear", 48'h0, cyc_out);
    $display("test cyclic done");
    end_sim();
  end
endmodule
